//--- clic_core.sv
// Purpose: Instruction interpreter of a character display controller.
// Assumes: Host strobes are one cycle, synchronous to core_clk.
// Notes: Glyph ROM and segment drivers sit outside; they use the scan ports.
`timescale 1ns/100ps
module clic_core #(
   parameter int CLEAR_CYC = clic_pkg::CLEAR_CYC,
   parameter int BLINK_CYC = clic_pkg::BLINK_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Host byte port
   input wire logic host_strobe,
   input wire logic reg_select,
   input wire logic read_write_select,
   input wire logic [7:0] host_wdata,
   output logic [7:0] host_rdata,
   // Mode and status
   output logic busy_flag,
   output logic [clic_pkg::AC_W-1:0] addr_counter,
   output logic step_direction,
   output logic auto_pan,
   output logic screen_enable,
   output logic pointer_mark_on,
   output logic flash_mark,
   output logic bus_width,
   output logic row_tally,
   output logic glyph_height,
   output logic blink_phase,
   output logic [6:0] pan_offset,
   output logic [4:0] common_count,
   // Text scan
   input wire logic scan_line,
   input wire logic [6:0] scan_col,
   output logic [7:0] scan_code,
   // Glyph scan
   input wire logic [7:0] glyph_code,
   input wire logic [2:0] glyph_row,
   input wire logic glyph_at_cursor,
   output logic [clic_pkg::GLYPH_W-1:0] glyph_pixels,
   output logic glyph_from_rom
);
   import clic_pkg::*;

   typedef struct packed {
      clic_state_e state;
      logic busy;
      logic [CNT_W-1:0] cnt;
      logic [6:0] ac;
      logic to_glyph;
      logic step_up;
      logic auto_pan;
      logic screen_enable;
      logic pointer_mark_on;
      logic flash_mark;
      logic bus_width;
      logic row_tally;
      logic glyph_height;
      logic [6:0] pan;
      logic [7:0] latch;
      logic [6:0] clr_idx;
      logic nib_second;
      logic [3:0] nib_hold;
      logic [7:0] rdata;
      logic blink_phase;
      logic [GLYPH_W-1:0] pixels;
      logic from_rom;
      logic [7:0] scan_code;
      logic [4:0] commons;
   } clic_core_s;

   clic_core_s s;
   clic_core_s next_s;

   clic_mem_if #(.AW(AC_W), .W(8)) tb ();
   clic_mem_if #(.AW(CG_AW), .W(GLYPH_W)) cg ();

   logic blink_tick;
   logic [7:0] byte_in;
   logic full;
   logic [7:0] rd_src;
   logic tb_wr;
   logic cg_wr;
   logic [6:0] tb_waddr;
   logic [7:0] tb_wdata;

   // Text buffer index from a display address
   function automatic logic [6:0] tb_index(input logic [6:0] a, input logic two);
      logic [6:0] r;
      r = a;
      if (two && a[6]) begin
         r = LINE_LEN + {1'b0, a[5:0]};
      end else if (two) begin
         r = {1'b0, a[5:0]};
      end
      return r;
   endfunction

   // Counter step with line wrap
   function automatic logic [6:0] ac_step(input logic [6:0] a, input logic up,
      input logic two, input logic glyph);
      logic [6:0] r;
      r = up ? a + 7'h01 : a - 7'h01;
      if (glyph) begin
         r = {1'b0, r[5:0]};
      end else if (two) begin
         if (up && a == LINE1_LAST) r = LINE2_BASE;
         else if (up && a == LINE2_LAST) r = HOME_ADDR;
         else if (!up && a == LINE2_BASE) r = LINE1_LAST;
         else if (!up && a == HOME_ADDR) r = LINE2_LAST;
      end else begin
         if (up && a == ONE_LAST) r = HOME_ADDR;
         else if (!up && a == HOME_ADDR) r = ONE_LAST;
      end
      return r;
   endfunction

   // Pan offset step; left shift shows later addresses
   function automatic logic [6:0] pan_step(input logic [6:0] p, input logic left,
      input logic two);
      logic [6:0] len;
      logic [6:0] r;
      len = two ? LINE_LEN : ONE_LEN;
      if (left) begin
         r = (p >= len - 7'h01) ? 7'h00 : p + 7'h01;
      end else begin
         r = (p == 7'h00) ? len - 7'h01 : p - 7'h01;
      end
      return r;
   endfunction

   // Display address seen at a screen column, all lines share one pan
   function automatic logic [6:0] view_addr(input logic line, input logic [6:0] col,
      input logic [6:0] p, input logic two);
      logic [6:0] len;
      logic [7:0] sum;
      logic [6:0] c;
      len = two ? LINE_LEN : ONE_LEN;
      sum = {1'b0, col} + {1'b0, p};
      if (sum >= {1'b0, len}) begin
         sum = sum - {1'b0, len};
      end
      c = sum[6:0];
      return (two && line) ? (LINE2_BASE | c) : c;
   endfunction

   // Storage
   clic_mem #(.AW(AC_W), .W(8), .DEPTH(TB_DEPTH)) u_text (
      .core_clk(core_clk),
      .port(tb.mem)
   );

   clic_mem #(.AW(CG_AW), .W(GLYPH_W), .DEPTH(CG_DEPTH)) u_glyph (
      .core_clk(core_clk),
      .port(cg.mem)
   );

   // Blink period divider, runs only while flashing
   clic_tick #(.PERIOD(BLINK_CYC)) u_blink (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .run(s.flash_mark),
      .tick(blink_tick)
   );

   // Memory port wiring
   assign tb.wr_en = tb_wr;
   assign tb.wr_addr = tb_waddr;
   assign tb.wr_data = tb_wdata;
   assign tb.rd_addr = tb_index(s.ac, s.row_tally);
   assign tb.scan_addr = tb_index(view_addr(scan_line, scan_col, s.pan, s.row_tally),
      s.row_tally);
   assign cg.wr_en = cg_wr;
   assign cg.wr_addr = s.ac[CG_AW-1:0];
   assign cg.wr_data = byte_in[GLYPH_W-1:0];
   assign cg.rd_addr = s.ac[CG_AW-1:0];
   assign cg.scan_addr = {glyph_code[2:0], glyph_row};

   // Next state
   always_comb begin
      next_s = s;
      full = 1'b0;
      byte_in = host_wdata;
      tb_wr = 1'b0;
      cg_wr = 1'b0;
      tb_waddr = tb_index(s.ac, s.row_tally);
      tb_wdata = host_wdata;

      // Byte assembly; four-bit mode pairs high then low nibble on bits 7..4
      if (host_strobe) begin
         if (s.bus_width) begin
            full = 1'b1;
         end else begin
            next_s.nib_second = !s.nib_second;
            if (s.nib_second) begin
               full = 1'b1;
               byte_in = {s.nib_hold, host_wdata[7:4]};
            end else begin
               next_s.nib_hold = host_wdata[7:4];
            end
         end
      end

      // Read answers: status or data latch, nibble by nibble in four-bit mode
      rd_src = reg_select ? s.latch : {s.busy, s.ac};
      tb_wdata = byte_in;
      if (host_strobe && read_write_select) begin
         if (s.bus_width) begin
            next_s.rdata = rd_src;
         end else if (s.nib_second) begin
            next_s.rdata = {rd_src[3:0], 4'h0};
         end else begin
            next_s.rdata = {rd_src[7:4], 4'h0};
         end
      end

      // Accept work only while idle; busy bytes are dropped
      if (full && s.state == ST_IDLE && !(!reg_select && read_write_select)) begin
         next_s.busy = 1'b1;
         next_s.state = ST_WAIT;
         next_s.cnt = CNT_W'(EXEC_CYC);
         if (!reg_select) begin
            // Instruction decode, highest set bit first
            if (byte_in[IB_DDADDR]) begin
               next_s.ac = byte_in[6:0];
               next_s.to_glyph = 1'b0;
               next_s.state = ST_FETCH;
            end else if (byte_in[IB_CGADDR]) begin
               next_s.ac = {1'b0, byte_in[5:0]};
               next_s.to_glyph = 1'b1;
               next_s.state = ST_FETCH;
            end else if (byte_in[IB_FUNC]) begin
               next_s.bus_width = byte_in[FUNC_DL_BIT];
               next_s.row_tally = byte_in[FUNC_N_BIT];
               next_s.glyph_height = byte_in[FUNC_F_BIT];
               next_s.nib_second = 1'b0;
            end else if (byte_in[IB_SHIFT]) begin
               if (byte_in[SHIFT_TGT_BIT]) begin
                  // Bit set means right, so display moves left when clear
                  next_s.pan = pan_step(s.pan, !byte_in[SHIFT_DIR_BIT],
                     s.row_tally);
               end else begin
                  next_s.ac = ac_step(s.ac, byte_in[SHIFT_DIR_BIT], s.row_tally,
                     s.to_glyph);
                  next_s.state = ST_FETCH;
               end
            end else if (byte_in[IB_DISP]) begin
               next_s.screen_enable = byte_in[DISP_ON_BIT];
               next_s.pointer_mark_on = byte_in[DISP_CUR_BIT];
               next_s.flash_mark = byte_in[DISP_BLINK_BIT];
            end else if (byte_in[IB_ENTRY]) begin
               next_s.step_up = byte_in[ENTRY_DIR_BIT];
               next_s.auto_pan = byte_in[ENTRY_PAN_BIT];
            end else if (byte_in[IB_HOME]) begin
               next_s.ac = HOME_ADDR;
               next_s.pan = 7'h00;
               next_s.to_glyph = 1'b0;
               next_s.cnt = CNT_W'(CLEAR_CYC);
            end else if (byte_in[IB_CLEAR]) begin
               next_s.ac = HOME_ADDR;
               next_s.pan = 7'h00;
               next_s.to_glyph = 1'b0;
               next_s.step_up = 1'b1;
               next_s.clr_idx = 7'h00;
               next_s.cnt = CNT_W'(CLEAR_CYC);
               next_s.state = ST_CLEAR;
            end
         end else if (!read_write_select) begin
            // Data write to the selected memory, then step
            tb_wr = !s.to_glyph;
            cg_wr = s.to_glyph;
            next_s.ac = ac_step(s.ac, s.step_up, s.row_tally, s.to_glyph);
            if (s.auto_pan && !s.to_glyph) begin
               next_s.pan = pan_step(s.pan, s.step_up, s.row_tally);
            end
         end else begin
            // Data read consumed; step and refill the latch
            next_s.ac = ac_step(s.ac, s.step_up, s.row_tally, s.to_glyph);
            next_s.state = ST_FETCH;
         end
      end

      // Execution timing
      unique case (s.state)
         ST_IDLE: begin
         end
         ST_CLEAR: begin
            tb_wr = 1'b1;
            tb_waddr = s.clr_idx;
            tb_wdata = SPACE_CODE;
            next_s.clr_idx = s.clr_idx + 7'h01;
            next_s.cnt = s.cnt - CNT_W'(1);
            if (s.clr_idx == 7'(TB_DEPTH - 1)) begin
               next_s.state = ST_WAIT;
            end
         end
         ST_FETCH: begin
            next_s.latch = s.to_glyph ? {3'h0, cg.rd_data} : tb.rd_data;
            next_s.cnt = s.cnt - CNT_W'(1);
            next_s.state = ST_WAIT;
         end
         ST_WAIT: begin
            if (s.cnt <= CNT_W'(1)) begin
               next_s.state = ST_IDLE;
               next_s.busy = 1'b0;
            end else begin
               next_s.cnt = s.cnt - CNT_W'(1);
            end
         end
      endcase

      // Blink phase toggles each period while flashing
      if (!s.flash_mark) begin
         next_s.blink_phase = 1'b0;
      end else if (blink_tick) begin
         next_s.blink_phase = !s.blink_phase;
      end

      // Glyph pixels for the display scan
      next_s.from_rom = glyph_code[7:4] != USER_CODE_HI;
      next_s.pixels = next_s.from_rom ? '0 : cg.scan_data;
      if (glyph_at_cursor && s.pointer_mark_on && glyph_row == CURSOR_ROW) begin
         next_s.pixels = next_s.pixels | ALL_LIT;
      end
      if (glyph_at_cursor && s.flash_mark && s.blink_phase) begin
         next_s.pixels = ALL_LIT;
      end
      if (!s.screen_enable) begin
         next_s.pixels = '0;
      end
      next_s.scan_code = tb.scan_data;
      next_s.commons = s.row_tally ? COMMONS_TWO : COMMONS_ONE;
   end

   // State register
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
         s.state <= ST_IDLE;
         s.step_up <= RST_STEP_UP;
         s.bus_width <= RST_BUS_WIDTH;
         s.row_tally <= RST_TWO_LINE;
         s.commons <= COMMONS_ONE;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register
   assign host_rdata = s.rdata;
   assign busy_flag = s.busy;
   assign addr_counter = s.ac;
   assign step_direction = s.step_up;
   assign auto_pan = s.auto_pan;
   assign screen_enable = s.screen_enable;
   assign pointer_mark_on = s.pointer_mark_on;
   assign flash_mark = s.flash_mark;
   assign bus_width = s.bus_width;
   assign row_tally = s.row_tally;
   assign glyph_height = s.glyph_height;
   assign blink_phase = s.blink_phase;
   assign pan_offset = s.pan;
   assign common_count = s.commons;
   assign scan_code = s.scan_code;
   assign glyph_pixels = s.pixels;
   assign glyph_from_rom = s.from_rom;
endmodule

//--- clic_core_properties.sv
// Purpose: Port-level properties of the instruction core.
// Assumes: Instruction checks apply to eight-bit transfers only.
// Notes: Bound onto clic_core at the foot of this file.
`timescale 1ns/100ps
module clic_core_checker
   import clic_pkg::*;
#(
   parameter int CLEAR_CYC = 7600
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Host port
   input wire logic host_strobe,
   input wire logic reg_select,
   input wire logic read_write_select,
   input wire logic [7:0] host_wdata,
   input wire logic [7:0] host_rdata,
   // Status and modes
   input wire logic busy_flag,
   input wire logic [clic_pkg::AC_W-1:0] addr_counter,
   input wire logic step_direction,
   input wire logic screen_enable,
   input wire logic pointer_mark_on,
   input wire logic flash_mark,
   input wire logic bus_width,
   input wire logic row_tally,
   input wire logic glyph_height
);
   logic [15:0] busy_len;
   logic take;
   logic acc;
   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   // Byte taken while idle, and the instruction case of it
   assign take = host_strobe && !busy_flag && bus_width;
   assign acc = take && !reg_select && !read_write_select;
   // Length of the current busy stretch
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) busy_len <= 16'h0000;
      else busy_len <= busy_flag ? busy_len + 16'h0001 : 16'h0000;
   end
   property p_busy; take && !(!reg_select && read_write_select) |=> busy_flag; endproperty
   a_busy: assert property (p_busy) else $error("busy did not rise");
   property p_stat; host_strobe && bus_width && !reg_select && read_write_select
      |=> host_rdata == {$past(busy_flag), $past(addr_counter)}; endproperty
   a_stat: assert property (p_stat) else $error("bad status byte");
   property p_dd; acc && host_wdata[7] |=> addr_counter == $past(host_wdata[6:0]); endproperty
   a_dd: assert property (p_dd) else $error("bad text address");
   property p_cg; acc && host_wdata[7:6] == 2'b01
      |=> addr_counter == {1'b0, $past(host_wdata[5:0])}; endproperty
   a_cg: assert property (p_cg) else $error("bad glyph address");
   property p_disp; acc && host_wdata[7:3] == 5'h01
      |=> {screen_enable, pointer_mark_on, flash_mark} == $past(host_wdata[2:0]); endproperty
   a_disp: assert property (p_disp) else $error("bad display bits");
   property p_func; acc && host_wdata[7:5] == 3'h1
      |=> {bus_width, row_tally, glyph_height} == $past(host_wdata[4:2]); endproperty
   a_func: assert property (p_func) else $error("bad function bits");
   property p_step; take && reg_select && step_direction && addr_counter < 7'h27
      |=> addr_counter == $past(addr_counter) + 7'h01; endproperty
   a_step: assert property (p_step) else $error("counter did not step");
   property p_len; $fell(busy_flag) |-> (busy_len == EXEC_CYC || busy_len == CLEAR_CYC);
   endproperty
   a_len: assert property (p_len) else $error("bad busy length");
   // Main scenarios reached
   c_clear: cover property (acc && host_wdata == 8'h01);
   c_stat: cover property (host_strobe && !reg_select && read_write_select);
   c_cg: cover property (acc && host_wdata[7:6] == 2'b01);
endmodule
bind clic_core clic_core_checker #(.CLEAR_CYC(CLEAR_CYC)) u_chk (.*);

//--- clic_core_tb.sv
// Purpose: Self-checking bench of the instruction core.
// Assumes: Eight-bit transfers apart from one four-bit passage; short clear and blink counts.
// Notes: Host model issues every byte and polls busy.
`timescale 1ns/100ps
module clic_core_tb;
   import clic_pkg::*;
   logic core_clk, host_strobe, reg_select, read_write_select, busy_flag, step_direction;
   logic screen_enable, pointer_mark_on, flash_mark, bus_width, row_tally, glyph_height;
   logic glyph_from_rom, auto_pan, blink_phase;
   logic [6:0] pan_offset;
   logic [7:0] n1, n2;
   logic [7:0] host_wdata, host_rdata, scan_code, d, q;
   logic [6:0] addr_counter, a;
   logic [4:0] common_count, glyph_pixels;
   logic rst_b = 1'b0;
   logic scan_line = 1'b0;
   logic glyph_at_cursor = 1'b0;
   logic [6:0] scan_col = 7'h00;
   logic [7:0] glyph_code = 8'h00;
   logic [2:0] glyph_row = 3'h0;
   logic [31:0] seed = 32'hf0f6055f;
   int n_fail = 0;
   int n_checks = 0;
   clic_core #(.CLEAR_CYC(100), .BLINK_CYC(8)) dut (.*);
   clic_host host (.*);
   // Clock
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Legal two-line address and its successor
   function automatic logic [6:0] legal(input logic [31:0] r);
      return {r[6], 6'(r[5:0] % 6'd40)};
   endfunction
   function automatic logic [6:0] nxt(input logic [6:0] p);
      return (p == 7'h27) ? 7'h40 : (p == 7'h67) ? 7'h00 : p + 7'h01;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmd(input logic rs, input logic [7:0] b);
      host.xfer(rs, 1'b0, b, q);
      host.ready();
   endtask
   task automatic look(input logic [6:0] c, input logic [7:0] exp);
      scan_col <= c;
      @(posedge core_clk);
      #1 chk(scan_code, exp);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (60000) @(posedge core_clk);
      n_fail++;
      test_done();
   end
   // Main sequence
   initial begin
      repeat (20) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      #1 chk({busy_flag, addr_counter}, 8'h00);
      chk({step_direction, bus_width, row_tally, common_count}, 8'hc8);
      cmd(1'b0, 8'h3c);
      chk({step_direction, bus_width, row_tally, common_count}, 8'hf0);
      chk({7'h00, glyph_height}, 8'h01);
      // Nibble mode: status polling is unsafe here, so wait out busy
      host.xfer(1'b0, 1'b0, 8'h2c, q);
      repeat (200) @(posedge core_clk);
      host.xfer(1'b0, 1'b0, 8'ha0, q);
      host.xfer(1'b0, 1'b0, 8'h50, q);
      repeat (200) @(posedge core_clk);
      host.xfer(1'b0, 1'b1, 8'h00, d);
      host.xfer(1'b0, 1'b1, 8'h00, q);
      chk({d[7:4], q[7:4]}, 8'h25);
      host.xfer(1'b0, 1'b0, 8'h30, q);
      host.xfer(1'b0, 1'b0, 8'hc0, q);
      repeat (200) @(posedge core_clk);
      #1 chk({7'h00, bus_width}, 8'h01);
      for (int v = 0; v < 8; v++) begin
         cmd(1'b0, 8'h08 | 8'(v));
         chk({5'h00, screen_enable, pointer_mark_on, flash_mark}, 8'(v));
      end
      cmd(1'b0, 8'h0c);
      $display("test modes done");
      host.xfer(1'b0, 1'b0, 8'ha7, q);
      host.xfer(1'b0, 1'b0, 8'h85, q);
      host.ready();
      chk({1'b0, addr_counter}, 8'h27);
      cmd(1'b1, 8'h55);
      host.xfer(1'b0, 1'b1, 8'h00, q);
      chk(q, 8'h40);
      cmd(1'b0, 8'h80);
      cmd(1'b1, 8'h41);
      cmd(1'b1, 8'h42);
      cmd(1'b0, 8'h18);
      chk({1'b0, addr_counter}, 8'h02);
      chk({auto_pan, pan_offset}, 8'h01);
      look(7'h00, 8'h42);
      cmd(1'b0, 8'h10);
      chk({1'b0, addr_counter}, 8'h01);
      cmd(1'b0, 8'h02);
      chk({1'b0, addr_counter}, 8'h00);
      look(7'h00, 8'h41);
      cmd(1'b0, 8'h07);
      cmd(1'b1, 8'h43);
      chk({auto_pan, pan_offset}, 8'h81);
      look(7'h00, 8'h42);
      cmd(1'b0, 8'h04);
      cmd(1'b1, 8'h44);
      look(7'h00, 8'h44);
      $display("test shifts done");
      cmd(1'b0, 8'h4b);
      cmd(1'b1, 8'h15);
      chk({1'b0, addr_counter}, 8'h0a);
      glyph_code <= 8'h09;
      glyph_row <= 3'h3;
      @(posedge core_clk);
      #1 chk({2'b00, glyph_from_rom, glyph_pixels}, 8'h15);
      glyph_code <= 8'h41;
      @(posedge core_clk);
      #1 chk({2'b00, glyph_from_rom, glyph_pixels}, 8'h20);
      // Cursor row: plain pattern away from the cursor, all lit at it
      cmd(1'b0, 8'h4f);
      cmd(1'b1, 8'h04);
      cmd(1'b0, 8'h0e);
      glyph_code <= 8'h09;
      glyph_row <= 3'h7;
      @(posedge core_clk);
      #1 chk({3'h0, glyph_pixels}, 8'h04);
      glyph_at_cursor <= 1'b1;
      @(posedge core_clk);
      #1 chk({3'h0, glyph_pixels}, 8'h1f);
      cmd(1'b0, 8'h01);
      chk({step_direction, addr_counter}, 8'h80);
      look(7'h27, 8'h20);
      // Blink: half of any two-period window is all lit
      cmd(1'b0, 8'h0d);
      glyph_row <= 3'h3;
      n1 = 8'h00;
      n2 = 8'h00;
      repeat (16) begin
         @(posedge core_clk);
         #1 n1 = n1 + 8'(glyph_pixels == ALL_LIT);
         n2 = n2 + 8'(blink_phase);
      end
      chk(n1, 8'h08);
      chk(n2, 8'h08);
      $display("test glyph and clear done");
      for (int i = 0; i < 16; i++) begin
         a = legal(rnd());
         d = 8'(rnd());
         cmd(1'b0, {1'b1, a});
         cmd(1'b1, d);
         host.xfer(1'b0, 1'b1, 8'h00, q);
         chk(q, {1'b0, nxt(a)});
         cmd(1'b0, {1'b1, a});
         cmd(1'b1, d ^ 8'hff);
         cmd(1'b0, {1'b1, a});
         host.xfer(1'b1, 1'b1, 8'h00, q);
         host.ready();
         chk(q, d ^ 8'hff);
         scan_line <= a[6];
         look({1'b0, a[5:0]}, d ^ 8'hff);
      end
      $display("test random done");
      test_done();
   end
endmodule

//--- clic_host.sv
// Purpose: Host processor model issuing bytes to the core.
// Assumes: Eight-bit parallel transfers.
// Notes: Lines change just after a rising edge.
`timescale 1ns/100ps
module clic_host (
   // Clock
   input wire logic core_clk,
   // Byte lines
   output logic host_strobe,
   output logic reg_select,
   output logic read_write_select,
   output logic [7:0] host_wdata,
   // Answer
   input wire logic [7:0] host_rdata
);
   // Quiet lines at time zero
   initial begin
      host_strobe = 1'b0;
      reg_select = 1'b0;
      read_write_select = 1'b0;
      host_wdata = 8'h00;
   end
   // One strobe; the select pair picks the target
   task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
      output logic [7:0] q);
      @(posedge core_clk);
      host_strobe <= 1'b1;
      reg_select <= rs;
      read_write_select <= rw;
      host_wdata <= d;
      @(posedge core_clk);
      host_strobe <= 1'b0;
      host_wdata <= ~d;
      #1 q = host_rdata;
   endtask
   // Poll status until ready, bounded
   task automatic ready();
      logic [7:0] s;
      s = 8'h80;
      for (int i = 0; i < 400 && s[7] !== 1'b0; i++) begin
         xfer(1'b0, 1'b1, 8'h00, s);
      end
   endtask
endmodule

//--- clic_mem.sv
// Purpose: Small storage array with one write port and two read ports.
// Assumes: Contents are not reset; the core clears what it must.
// Notes: Addresses past the depth read as zero and drop writes.
`timescale 1ns/100ps
module clic_mem #(
   parameter int AW = 7,
   parameter int W = 8,
   parameter int DEPTH = 80
) (
   // Clock
   input wire logic core_clk,
   // Access ports
   clic_mem_if.mem port
);
   logic [W-1:0] cells [DEPTH];

   // Write on the rising edge
   always_ff @(posedge core_clk) begin
      if (port.wr_en && (int'(port.wr_addr) < DEPTH)) begin
         cells[port.wr_addr] <= port.wr_data;
      end
   end

   // Asynchronous reads for host and display scan
   assign port.rd_data = (int'(port.rd_addr) < DEPTH) ? cells[port.rd_addr] : '0;
   assign port.scan_data = (int'(port.scan_addr) < DEPTH) ? cells[port.scan_addr] : '0;
endmodule

//--- clic_mem_if.sv
// Purpose: Carrier between the core and one of its memories.
// Assumes: One write port and two asynchronous read ports.
// Notes: The mem modport is the storage side.
`timescale 1ns/100ps
interface clic_mem_if #(parameter int AW = 7, parameter int W = 8);
   logic wr_en;
   logic [AW-1:0] wr_addr;
   logic [W-1:0] wr_data;
   logic [AW-1:0] rd_addr;
   logic [W-1:0] rd_data;
   logic [AW-1:0] scan_addr;
   logic [W-1:0] scan_data;
   modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr,
      input scan_addr, output rd_data, output scan_data);
   modport user (output wr_en, output wr_addr, output wr_data, output rd_addr,
      output scan_addr, input rd_data, input scan_data);
endinterface

//--- clic_pkg.sv
// Purpose: Shared constants and types of the character display instruction core.
// Assumes: 10 MHz core clock; host bytes arrive as single-cycle strobes.
// Notes: Timing counts are derived here from the printed times and the clock period.
package clic_pkg;
   // Address counter and memory shapes
   localparam int AC_W = 7;
   localparam int CG_AW = 6;
   localparam int GLYPH_W = 5;
   localparam int TB_DEPTH = 80;
   localparam int CG_DEPTH = 64;
   localparam int CNT_W = 16;
   // Text buffer address map
   localparam logic [6:0] HOME_ADDR = 7'h00;
   localparam logic [6:0] LINE1_LAST = 7'h27;
   localparam logic [6:0] LINE2_BASE = 7'h40;
   localparam logic [6:0] LINE2_LAST = 7'h67;
   localparam logic [6:0] ONE_LAST = 7'h4f;
   localparam logic [6:0] LINE_LEN = 7'h28;
   localparam logic [6:0] ONE_LEN = 7'h50;
   localparam logic [7:0] SPACE_CODE = 8'h20;
   // Instruction opcode bits, highest set bit wins
   localparam int IB_CLEAR = 0;
   localparam int IB_HOME = 1;
   localparam int IB_ENTRY = 2;
   localparam int IB_DISP = 3;
   localparam int IB_SHIFT = 4;
   localparam int IB_FUNC = 5;
   localparam int IB_CGADDR = 6;
   localparam int IB_DDADDR = 7;
   // Operand fields
   localparam int ENTRY_DIR_BIT = 1;
   localparam int ENTRY_PAN_BIT = 0;
   localparam int DISP_ON_BIT = 2;
   localparam int DISP_CUR_BIT = 1;
   localparam int DISP_BLINK_BIT = 0;
   localparam int SHIFT_TGT_BIT = 3;
   localparam int SHIFT_DIR_BIT = 2;
   localparam int FUNC_DL_BIT = 4;
   localparam int FUNC_N_BIT = 3;
   localparam int FUNC_F_BIT = 2;
   // Glyph mapping
   localparam logic [2:0] CURSOR_ROW = 3'h7;
   localparam logic [4:0] ALL_LIT = 5'h1f;
   localparam logic [3:0] USER_CODE_HI = 4'h0;
   localparam logic [4:0] COMMONS_TWO = 5'h10;
   localparam logic [4:0] COMMONS_ONE = 5'h08;
   // Reset values of the mode bits
   localparam logic RST_BUS_WIDTH = 1'b1;
   localparam logic RST_STEP_UP = 1'b1;
   localparam logic RST_TWO_LINE = 1'b0;
   // Timing, printed figures in ns, counts in core cycles (longest times round down)
   localparam int CLK_PERIOD_NS = 100;
   localparam int EXEC_TIME_NS = 18500;
   localparam int CLEAR_TIME_NS = 760000;
   localparam int BLINK_TIME_NS = 185000000;
   localparam int EXEC_CYC = (EXEC_TIME_NS / CLK_PERIOD_NS < 2) ? 2 :
      EXEC_TIME_NS / CLK_PERIOD_NS;
   localparam int CLEAR_CYC = CLEAR_TIME_NS / CLK_PERIOD_NS;
   localparam int BLINK_CYC = BLINK_TIME_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {ST_IDLE, ST_CLEAR, ST_FETCH, ST_WAIT} clic_state_e;
endpackage

//--- clic_tick.sv
// Purpose: Divider giving a one-cycle pulse every PERIOD cycles while enabled.
// Assumes: Single core clock.
// Notes: Disabling restarts the count.
`timescale 1ns/100ps
module clic_tick #(
   parameter int PERIOD = 1850000
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Control and pulse
   input wire logic run,
   output logic tick
);
   localparam int TW = $clog2(PERIOD + 1);
   typedef struct packed {
      logic [TW-1:0] cnt;
      logic tick;
   } clic_tick_s;
   clic_tick_s s;
   clic_tick_s next_s;

   // Count up and pulse at the end of each period
   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      if (!run) begin
         next_s.cnt = '0;
      end else if (s.cnt == TW'(PERIOD - 1)) begin
         next_s.cnt = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.cnt = s.cnt + TW'(1);
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick = s.tick;
endmodule
